// ==== core/ccl_pkg.sv ====
// Package with constants for the clock conditioner config loader
// Notes on behaviour
// - Loader shifts all 81 bits (89 in the mixed-signal variant) before update
// - After shifting, drop shift, pulse update, apply
// - Update strobe never high while shifting
// - Update strobe returns low until next update
// - Bits 71-73 and 77-80 carry no function
// - Bits 88:87 select glitchless mux inputs
// - Bit 86 enables half-step divide, output C
// - Bit 85 enables half-step divide, output B
// - Bit 84 enables half-step divide, output A
// - Bits 81-88 exist only in mixed-signal variant
// - JTAG bridge drives shift and update, no pins
// - Core-logic loader generates data, shift, update
// - External controller may drive the same signals
// - Mode low selects static configuration instead
package ccl_pkg;
  localparam int CFG_BITS_STD = 81;
  localparam int CFG_BITS_MIX = 89;
  localparam int DONT_CARE_A_LO = 71;
  localparam int DONT_CARE_A_HI = 73;
  localparam int DONT_CARE_B_LO = 77;
  localparam int DONT_CARE_B_HI = 80;
  localparam int MUX_SEL_LSB = 87;
  localparam int MUX_SEL_MSB = 88;
  localparam int OUT_C_HALF_POS = 86;
  localparam int OUT_B_HALF_POS = 85;
  localparam int OUT_A_HALF_POS = 84;
  localparam int RC_OSC_MHZ = 100;
  localparam logic [88:0] ACTIVE_RESET = 89'h0;
  localparam logic [6:0] COUNT_RESET = 7'h00;
endpackage

// ==== core/ccl_link_if.sv ====
// Serial configuration link between loader and clock conditioner
`timescale 1ns/1ps
interface ccl_link_if;
  logic serial_config_in;
  logic shift_enable_ctl;
  logic update_strobe;
  modport loader (output serial_config_in, output shift_enable_ctl, output update_strobe);
  modport conditioner (input serial_config_in, input shift_enable_ctl, input update_strobe);
endinterface

// ==== core/ccl_conditioner.sv ====
// Clock conditioner end: config shift register and active configuration latch
`timescale 1ns/1ps
module ccl_conditioner #(
  parameter bit MIXED_SIGNAL = 1'b1
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Serial link from the loader
  ccl_link_if.conditioner link,
  // Mode and static configuration
  input wire logic dynamic_mode_in,
  input wire logic [88:0] static_cfg_in,
  // Effective configuration, decoded fields and update acknowledge
  output logic [88:0] active_cfg_out,
  output logic [1:0] glitchless_mux_select_out,
  output logic out_c_half_step_out,
  output logic out_b_half_step_out,
  output logic out_a_half_step_out,
  output logic update_seen_out
);
  // Shift register group
  logic [88:0] shift_reg;
  logic [88:0] shift_next;
  // Active configuration latch group
  logic [88:0] latch_reg;
  logic [88:0] latch_next;
  // Update acknowledge group
  logic seen_reg;
  logic seen_next;
  // Effective configuration group, source of every data output
  logic [88:0] eff_reg;
  logic [88:0] eff_next;
  // Update accepted only outside a shift; a clash lets the shift win
  logic take_update;

  // Clear positions without function in this variant
  function automatic logic [88:0] cfg_mask(input logic [88:0] cfg_word);
    logic [88:0] kept;
    kept = cfg_word;
    for (int i = 0; i < ccl_pkg::CFG_BITS_MIX; i++) begin
      if ((i >= ccl_pkg::DONT_CARE_A_LO && i <= ccl_pkg::DONT_CARE_A_HI) ||
          (i >= ccl_pkg::DONT_CARE_B_LO && i <= ccl_pkg::DONT_CARE_B_HI)) begin
        kept[i] = 1'b0;
      end else if (!MIXED_SIGNAL && i >= ccl_pkg::CFG_BITS_STD) begin
        kept[i] = 1'b0;
      end
    end
    return kept;
  endfunction

  // Update qualifier shared by latch and acknowledge
  assign take_update = link.update_strobe && !link.shift_enable_ctl;

  // Shift register next value, one bit per enabled edge
  always_comb begin
    shift_next = shift_reg;
    if (link.shift_enable_ctl) begin
      // New bit enters at the top, so the first bit sent lands in bit 0
      if (MIXED_SIGNAL) begin
        shift_next = {link.serial_config_in, shift_reg[88:1]};
      end else begin
        // Short variant: the top eight positions stay clear
        shift_next = {8'h00, link.serial_config_in, shift_reg[80:1]};
      end
    end
  end

  // Shift register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      shift_reg <= ccl_pkg::ACTIVE_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Latch next value, whole word copied in one cycle
  always_comb begin
    latch_next = latch_reg;
    if (take_update) begin
      latch_next = cfg_mask(shift_reg);
    end
  end

  // Active configuration latch, holds until the next update
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      latch_reg <= ccl_pkg::ACTIVE_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // Acknowledge next value, one cycle per accepted update
  always_comb begin
    seen_next = take_update;
  end

  // Acknowledge register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= seen_next;
    end
  end

  // Effective source; the dynamic path follows the new latch without delay
  always_comb begin
    eff_next = cfg_mask(static_cfg_in);
    if (dynamic_mode_in) begin
      eff_next = latch_next;
    end
  end

  // Effective configuration register, keeps data outputs glitch free
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      eff_reg <= ccl_pkg::ACTIVE_RESET;
    end else begin
      eff_reg <= eff_next;
    end
  end

  // Field decode from the registered configuration
  assign active_cfg_out = eff_reg;
  assign glitchless_mux_select_out = eff_reg[ccl_pkg::MUX_SEL_MSB:ccl_pkg::MUX_SEL_LSB];
  assign out_c_half_step_out = eff_reg[ccl_pkg::OUT_C_HALF_POS];
  assign out_b_half_step_out = eff_reg[ccl_pkg::OUT_B_HALF_POS];
  assign out_a_half_step_out = eff_reg[ccl_pkg::OUT_A_HALF_POS];
  assign update_seen_out = seen_reg;
endmodule

// ==== core/ccl_loader.sv ====
// Loader end: core-logic style controller shifting and updating a config word
`timescale 1ns/1ps
module ccl_loader (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // User request
  input wire logic start_in,
  input wire logic [88:0] cfg_word_in,
  input wire logic mixed_signal_in,
  output logic busy_out,
  output logic done_out,
  // Serial link to the conditioner
  ccl_link_if.loader link
);
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_UPDATE} ccl_state_t;
  ccl_state_t state_reg;
  ccl_state_t state_next;
  logic [88:0] data_reg;
  logic [88:0] data_next;
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] last_cnt;
  logic done_reg;
  logic done_next;

  // Length follows the variant: 81 or 89 bits
  assign last_cnt = mixed_signal_in ? 7'(ccl_pkg::CFG_BITS_MIX - 1)
                                    : 7'(ccl_pkg::CFG_BITS_STD - 1);

  // Sequencer next-state
  always_comb begin
    state_next = state_reg;
    data_next = data_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_in) begin
          data_next = cfg_word_in;
          cnt_next = ccl_pkg::COUNT_RESET;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        data_next = {1'b0, data_reg[88:1]};
        cnt_next = cnt_reg + 7'h01;
        if (cnt_reg == last_cnt) begin
          state_next = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        state_next = ST_IDLE;
        done_next = 1'b1;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      data_reg <= ccl_pkg::ACTIVE_RESET;
      cnt_reg <= ccl_pkg::COUNT_RESET;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  // Link drive: update only in its own single cycle, never while shifting
  assign link.serial_config_in = (state_reg == ST_SHIFT) ? data_reg[0] : 1'b0;
  assign link.shift_enable_ctl = (state_reg == ST_SHIFT);
  assign link.update_strobe = (state_reg == ST_UPDATE);
  assign busy_out = (state_reg != ST_IDLE);
  assign done_out = done_reg;
endmodule

// ==== bench/ccl_assertions.sv ====
// Checker for the serial configuration link between the two ends
`timescale 1ns/1ps
module ccl_assertions #(parameter int N_BITS = 89) (
  // Clock, reset and link
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic serial_config_in,
  input wire logic shift_enable_ctl,
  input wire logic update_strobe
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Shifts seen since the last update
  always_comb cnt_next = update_strobe ? 7'h00 : cnt_reg + 7'(shift_enable_ctl);
  always_ff @(posedge mclk_in) cnt_reg <= rst_n_in ? cnt_next : 7'h00;
  a_no_update_shift: assert property (update_strobe |-> !shift_enable_ctl)
    else $error("update strobe high while shifting");
  a_update_pulse: assert property (update_strobe |=> !update_strobe [*8])
    else $error("update strobe not returned low");
  a_shift_then_update: assert property ($fell(shift_enable_ctl) |-> update_strobe)
    else $error("no update after last shift");
  a_update_after_shift: assert property (update_strobe |-> $past(shift_enable_ctl))
    else $error("update without preceding shift");
  a_full_count: assert property (update_strobe |-> cnt_reg == 7'(N_BITS))
    else $error("update before all bits shifted");
  a_count_limit: assert property (shift_enable_ctl |-> cnt_reg < 7'(N_BITS))
    else $error("too many bits shifted");
  a_shift_run: assert property ($rose(shift_enable_ctl) |-> shift_enable_ctl [*8])
    else $error("shift run broken early");
  a_data_idle_low: assert property (!shift_enable_ctl |-> !serial_config_in)
    else $error("data bit high outside shifting");
  a_bits_no_gap: assert property (shift_enable_ctl && cnt_reg < 7'(N_BITS - 1)
    |=> shift_enable_ctl)
    else $error("gap inside shift run");
endmodule

// ==== bench/tb.sv ====
// Testbench: loader feeds conditioner, bench model checks results
`timescale 1ns/1ps
module tb;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_in = 1'b0;
  logic mode = 1'b1;
  logic [88:0] word = '0;
  logic [88:0] stat = '0;
  logic [88:0] sr = '0;
  logic [88:0] act;
  logic [1:0] msel;
  logic hc, hb, ha, seen, busy, done;
  logic [31:0] lf = 32'h0000004f;
  int n_errors = 0;
  int n_compared = 0;
  ccl_link_if link();
  ccl_loader u_ccl_loader(.mclk_in(mclk_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .cfg_word_in(word), .mixed_signal_in(1'b1), .busy_out(busy), .done_out(done), .link(link));
  ccl_conditioner u_ccl_conditioner(.mclk_in(mclk_in), .rst_n_in(rst_n_in), .link(link),
    .dynamic_mode_in(mode), .static_cfg_in(stat), .active_cfg_out(act),
    .glitchless_mux_select_out(msel), .out_c_half_step_out(hc), .out_b_half_step_out(hb),
    .out_a_half_step_out(ha), .update_seen_out(seen));
  ccl_assertions #(.N_BITS(89)) u_chk(.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .serial_config_in(link.serial_config_in), .shift_enable_ctl(link.shift_enable_ctl),
    .update_strobe(link.update_strobe));
  // Clock
  always #2.5 mclk_in = ~mclk_in;
  // Model of the conditioner shift register, first bit ends lowest
  always @(posedge mclk_in) begin
    if (link.shift_enable_ctl === 1'b1) begin
      sr <= {link.serial_config_in, sr[88:1]};
    end
  end
  function automatic logic [88:0] msk(input logic [88:0] w);
    msk = w;
    msk[73:71] = 3'h0;
    msk[80:77] = 4'h0;
  endfunction
  function automatic logic [88:0] rnd();
    logic [88:0] r;
    for (int j = 0; j < 89; j++) begin
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      r[j] = lf[0];
    end
    return r;
  endfunction
  task automatic chk(input string nm, input logic [88:0] e, input logic [88:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One load, with a second start while busy that must be ignored
  task automatic load(input logic [88:0] w);
    int i;
    i = 0;
    @(posedge mclk_in);
    word <= w;
    start_in <= 1'b1;
    @(posedge mclk_in);
    word <= ~w;
    @(posedge mclk_in);
    start_in <= 1'b0;
    #1;
    chk("busy", 89'(1'b1), 89'(busy));
    do begin
      @(posedge mclk_in);
      #1;
      i++;
    end while (seen !== 1'b1 && i < 200);
    chk("seen", 89'(1'b1), 89'(seen));
    chk("wire", w, sr);
    chk("active", msk(w), act);
    chk("done", 89'(1'b1), 89'(done));
    chk("idle", 89'(1'b0), 89'(busy));
    chk("fields", 89'(w[88:84]), 89'({msel, hc, hb, ha}));
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk("reset", '0, act);
    load('1);
    for (int k = 0; k < 6; k++) load(rnd());
    @(posedge mclk_in);
    mode <= 1'b0;
    stat <= rnd();
    @(posedge mclk_in);
    #1;
    chk("static", msk(stat), act);
    end_sim();
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    end_sim();
  end
endmodule
